// ===== rtl/cac_control.sv
/*
 Control and cipher configuration registers of the crypto accelerator,
 with AXI4-Lite slave, byte swap paths, hash source mux, interrupt,
 soft reset sequencer and key load steering.
 Assumes engine status inputs on aclk, and that the FIFO words are
 presented with a full-word flag.
*/
// Decided for this implementation: the AXI4-Lite slave port.
// Function
// R1: Input byte-swap bit reverses bytes of each incoming word.
// R2: Output byte-swap bit reverses bytes of each outgoing word.
// R3: Partial words are never byte swapped.
// R4: Source bit feeds hash/CRC from input FIFO (0) or output FIFO (1).
// R5: Interrupt enable raises interrupt on done or error.
// R6: Writing 1 to soft-reset starts internal reset; writing 0 does nothing.
// R7: Soft reset clears engine state, keeps control register contents.
// R8: Software polls ready bit after soft reset before further operations.
// R9: CCM L field reads codes 1..7 for L 2..8, 0 reserved.
// R10: CCM M field reads codes 1..7 for tag 4..16, 0 reserved.
// R11: Data type bit reads 0 for AAD, 1 for payload.
// R12: H-vector bit shows computation busy, cleared by hardware at end.
// R13: Mode field selects ECB..CCM with codes 0..6, 7 reserved.
// R14: Algorithm field: off, AES-128/192/256, DES, triple DES; 6,7 reserved.
// R15: Software clears algorithm field before non-AES operations.
// R16: Key origin 0b00 software key words, 0b10 user NV key area.
// R17: Each key load moves 128 key bits into working key registers.
// R18: 256-bit key needs two loads, origin 0b10 then 0b11.
// R19: DES always takes key from software key words.
// R20: Cipher done flag set on cipher completion, cleared by software.
// R21: Writing 1 to key-load bit starts DMA key load.
// R22: Reserved bits read zero and ignore writes.
// R23: Software leaves the wait-pin enable bit at zero.
`timescale 1ns/1ps
`default_nettype none
`include "cac_defines.svh"
module cac_control #(
    parameter int SRST_CYCLES = `CAC_SRST_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire cac_pkg::cac_word_t fifo_in,
    input wire cac_pkg::cac_word_t fifo_out,
    output cac_pkg::cac_word_t engine_in,
    output cac_pkg::cac_word_t engine_out,
    output cac_pkg::cac_word_t hash_in,
    input wire logic cipher_done,
    input wire logic other_done,
    input wire logic engine_err,
    input wire logic [2:0] ccm_l,
    input wire logic [2:0] ccm_m,
    input wire logic payload_phase,
    input wire logic hvc_start,
    input wire logic hvc_done,
    output logic soft_reset,
    output logic key_load_start,
    output logic key_from_nv,
    output logic key_upper_half,
    output logic irq
);
    import cac_pkg::*;

    cac_state_t q;
    cac_state_t d;
    logic wr_go;
    logic rd_go;
    logic [31:0] be;
    logic [31:0] wr_main;
    logic [31:0] wr_ciph;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic cac_word_t swap_word(input cac_word_t w, input logic en);
        cac_word_t r;
        r = w;
        if (en && w.full)
        begin
            r.data = {w.data[7:0], w.data[15:8], w.data[23:16], w.data[31:24]};
        end
        return r;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [31:0] m);
        return (old & ~m) | (nw & m);
    endfunction

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !q.bvalid;
    assign rd_go = s_axi_arvalid && !q.rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = q.rdata;
    assign engine_in = q.in_w;
    assign engine_out = q.out_w;
    assign hash_in = q.hash_w;
    assign soft_reset = (q.sr_state == CAC_SR_BUSY);
    assign key_load_start = q.key_load;
    assign key_from_nv = q.key_from_nv;
    assign key_upper_half = q.key_upper;
    assign irq = q.irq;

    always_comb
    begin
        be = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
            {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
        wr_main = merge(q.main_ctl, s_axi_wdata, be & `CAC_M_WMASK); // R22
        wr_ciph = merge(q.ciph_ctl, s_axi_wdata, be & `CAC_C_WMASK); // R13 R14 R22
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        d = q;
        d.key_load = 1'b0;
        if (q.bvalid && s_axi_bready)
        begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && s_axi_rready)
        begin
            d.rvalid = 1'b0;
        end
        if (wr_go)
        begin
            d.bvalid = 1'b1;
            d.bresp = `CAC_RESP_OKAY;
            if (s_axi_awaddr == `CAC_OFF_MAIN)
            begin
                d.main_ctl = wr_main;
                if (s_axi_wstrb[0] && s_axi_wdata[`CAC_M_RST])
                begin
                    d.sr_state = CAC_SR_BUSY; // R6
                    d.sr_cnt = '0;
                end
            end
            else if (s_axi_awaddr == `CAC_OFF_CIPH)
            begin
                d.ciph_ctl = wr_ciph;
                d.key_load = s_axi_wstrb[0] && s_axi_wdata[`CAC_C_KEY]; // R21
            end
            else
            begin
                d.bresp = `CAC_RESP_SLVERR;
            end
        end
        if (rd_go)
        begin
            d.rvalid = 1'b1;
            d.rresp = `CAC_RESP_OKAY;
            if (s_axi_araddr == `CAC_OFF_MAIN)
            begin
                d.rdata = q.main_ctl;
                d.rdata[`CAC_M_RST] = (q.sr_state == CAC_SR_BUSY);
                d.rdata[`CAC_M_RDY] = (q.sr_state == CAC_SR_IDLE);
            end
            else if (s_axi_araddr == `CAC_OFF_CIPH)
            begin
                d.rdata = q.ciph_ctl;
            end
            else
            begin
                d.rdata = 32'h0000_0000;
                d.rresp = `CAC_RESP_SLVERR;
            end
        end
        // Soft reset sequencer; engine state only
        case (q.sr_state)
            CAC_SR_IDLE:
            begin
            end
            CAC_SR_BUSY:
            begin
                d.sr_cnt = q.sr_cnt + 8'h01;
                if (q.sr_cnt == 8'(SRST_CYCLES - 1))
                begin
                    d.sr_state = CAC_SR_IDLE;
                end
            end
            default:
            begin
                d.sr_state = CAC_SR_IDLE;
            end
        endcase
        // Engine status fields
        d.ciph_ctl[`CAC_C_CCML_LO +: 3] = ccm_l; // R9
        d.ciph_ctl[`CAC_C_CCMM_LO +: 3] = ccm_m; // R10
        d.ciph_ctl[`CAC_C_DTYPE] = payload_phase; // R11
        if (hvc_done)
        begin
            d.ciph_ctl[`CAC_C_HVC] = 1'b0; // R12
        end
        if (soft_reset)
        begin
            d.ciph_ctl[`CAC_C_HVC] = 1'b0; // R7
            d.main_ctl[`CAC_M_CPH_DONE] = 1'b0; // R7
            d.in_w = '0;
            d.out_w = '0;
            d.hash_w = '0;
        end
        if (hvc_start)
        begin
            d.ciph_ctl[`CAC_C_HVC] = 1'b1; // R12
        end
        if (cipher_done)
        begin
            d.main_ctl[`CAC_M_CPH_DONE] = 1'b1; // R20
        end
        d.main_ctl[`CAC_M_RST] = 1'b0;
        if (!soft_reset)
        begin
            d.in_w = swap_word(fifo_in, q.main_ctl[`CAC_M_BSI]); // R1 R3
            d.out_w = swap_word(fifo_out, q.main_ctl[`CAC_M_BSO]); // R2 R3
            d.hash_w = q.main_ctl[`CAC_M_SRC] ? fifo_out : fifo_in; // R4
        end
        d.key_from_nv = q.ciph_ctl[`CAC_C_KSRC_LO + 1]
            && (q.ciph_ctl[`CAC_C_ALG_LO +: 3] != CAC_ALG_DES); // R16 R19
        d.key_upper = q.ciph_ctl[`CAC_C_KSRC_LO] && d.key_from_nv; // R17
        d.irq = q.main_ctl[`CAC_M_INTR]
            && (q.main_ctl[`CAC_M_CPH_DONE] || other_done || engine_err); // R5
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
            q.main_ctl <= `CAC_M_RESET;
            q.ciph_ctl <= `CAC_C_RESET;
            q.sr_state <= CAC_SR_IDLE;
        end
        else
        begin
            q <= d;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    localparam int SRST_LAST = SRST_CYCLES - 1;

    a_swap_in_full: assert property ( // R1
        fifo_in.full && !soft_reset && q.main_ctl[`CAC_M_BSI] |=>
        engine_in.data == {$past(fifo_in.data[7:0]), $past(fifo_in.data[15:8]),
        $past(fifo_in.data[23:16]), $past(fifo_in.data[31:24])})
        else $error("input swap wrong");
    a_swap_out_full: assert property ( // R2
        fifo_out.full && !soft_reset && q.main_ctl[`CAC_M_BSO] |=>
        engine_out.data == {$past(fifo_out.data[7:0]), $past(fifo_out.data[15:8]),
        $past(fifo_out.data[23:16]), $past(fifo_out.data[31:24])})
        else $error("output swap wrong");
    a_partial_pass: assert property ( // R3
        !fifo_in.full && !soft_reset |=> engine_in.data == $past(fifo_in.data))
        else $error("partial word swapped");
    a_hash_src: assert property ( // R4
        !soft_reset && q.main_ctl[`CAC_M_SRC] |=> hash_in == $past(fifo_out))
        else $error("hash source wrong");
    a_irq_gate: assert property ( // R5
        !q.main_ctl[`CAC_M_INTR] |=> !irq)
        else $error("irq while disabled");
    a_irq_err: assert property ( // R5
        q.main_ctl[`CAC_M_INTR] && engine_err |=> irq)
        else $error("irq missing");
    a_srst_len: assert property ( // R6
        $rose(soft_reset) |-> ##SRST_LAST soft_reset ##1 !soft_reset)
        else $error("soft reset length wrong");
    a_srst_keep: assert property ( // R7
        soft_reset && !wr_go |=> $stable(q.main_ctl[`CAC_M_INTR +: 6]))
        else $error("control lost in soft reset");
    a_ccm_l: assert property ( // R9
        1'b1 |=> q.ciph_ctl[`CAC_C_CCML_LO +: 3] == $past(ccm_l))
        else $error("ccm l not tracked");
    a_hvc_clear: assert property ( // R12
        hvc_done && !hvc_start |=> !q.ciph_ctl[`CAC_C_HVC])
        else $error("hvc not cleared");
    a_des_key: assert property ( // R19
        q.ciph_ctl[`CAC_C_ALG_LO +: 3] == CAC_ALG_DES |=> !key_from_nv)
        else $error("des key from nv");
    a_done_set: assert property ( // R20
        cipher_done |=> q.main_ctl[`CAC_M_CPH_DONE])
        else $error("done flag lost");
    a_key_pulse: assert property ( // R21
        key_load_start |=> !key_load_start)
        else $error("key load not a pulse");
    a_resv_zero: assert property ( // R22
        s_axi_rvalid && s_axi_rresp == `CAC_RESP_OKAY |->
        (s_axi_rdata & 32'he000_0080) == 32'h0000_0000)
        else $error("reserved bits set");
    a_ccm_m: assert property ( // R10
        1'b1 |=> q.ciph_ctl[`CAC_C_CCMM_LO +: 3] == $past(ccm_m))
        else $error("ccm m not tracked");
    a_dtype_track: assert property ( // R11
        1'b1 |=> q.ciph_ctl[`CAC_C_DTYPE] == $past(payload_phase))
        else $error("data type not tracked");
    a_hvc_set: assert property ( // R12
        hvc_start |=> q.ciph_ctl[`CAC_C_HVC])
        else $error("hvc not set");
    a_srst_zero: assert property ( // R7
        soft_reset |=> engine_in == '0 && engine_out == '0 && hash_in == '0)
        else $error("data path not cleared");
    a_mode_store: assert property ( // R13
        wr_go && s_axi_awaddr == `CAC_OFF_CIPH && s_axi_wstrb[1] |=>
        q.ciph_ctl[`CAC_C_MODE_LO +: 3] == $past(s_axi_wdata[`CAC_C_MODE_LO +: 3]))
        else $error("mode not stored");
    a_alg_store: assert property ( // R14
        wr_go && s_axi_awaddr == `CAC_OFF_CIPH && s_axi_wstrb[0] |=>
        q.ciph_ctl[`CAC_C_ALG_LO +: 3] == $past(s_axi_wdata[`CAC_C_ALG_LO +: 3]))
        else $error("algorithm not stored");
    a_key_upper: assert property ( // R17
        q.ciph_ctl[`CAC_C_KSRC_LO +: 2] == 2'h3
        && q.ciph_ctl[`CAC_C_ALG_LO +: 3] != CAC_ALG_DES |=> key_upper_half)
        else $error("upper key half missing");
    a_rst_w0: assert property ( // R6
        wr_go && s_axi_awaddr == `CAC_OFF_MAIN && !s_axi_wdata[`CAC_M_RST]
        && !soft_reset |=> !soft_reset)
        else $error("soft reset on zero write");

    c_soft_reset: cover property ($fell(soft_reset));
    c_irq: cover property ($rose(irq));
    c_key_nv: cover property (key_load_start && key_from_nv);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `CAC_RESP_SLVERR);
endmodule
`default_nettype wire

// ===== rtl/cac_defines.svh
/*
 Register offsets, field positions, masks and timing counts of the
 accelerator control block. Assumes inclusion by the control module.
*/
`ifndef CAC_DEFINES_SVH
`define CAC_DEFINES_SVH
// ----------------------------------------
// Offsets
// ----------------------------------------
`define CAC_OFF_MAIN 4'h0
`define CAC_OFF_CIPH 4'h4
// ----------------------------------------
// Main control fields
// ----------------------------------------
`define CAC_M_RST 0
`define CAC_M_INTR 1
`define CAC_M_SRC 2
`define CAC_M_BSO 4
`define CAC_M_BSI 5
`define CAC_M_CPH_DONE 27
`define CAC_M_RDY 28
`define CAC_M_WMASK 32'h0800_0076
`define CAC_M_RESET 32'h0000_0000
// ----------------------------------------
// Cipher control fields
// ----------------------------------------
`define CAC_C_ENC 0
`define CAC_C_KEY 1
`define CAC_C_KSRC_LO 2
`define CAC_C_ALG_LO 4
`define CAC_C_MODE_LO 8
`define CAC_C_HVC 11
`define CAC_C_DTYPE 12
`define CAC_C_CCMM_LO 13
`define CAC_C_CCML_LO 16
`define CAC_C_WMASK 32'h0000_077f
`define CAC_C_RESET 32'h0000_0000
`define CAC_KSRC_SW 2'h0
`define CAC_KSRC_NV 2'h2
`define CAC_KEY_BITS 128
// ----------------------------------------
// Timing and bus response codes
// ----------------------------------------
`define CAC_SRST_NS 200
`define CAC_CLK_NS 50
`define CAC_SRST_CYC ((`CAC_SRST_NS + `CAC_CLK_NS - 1) / `CAC_CLK_NS)
`define CAC_RESP_OKAY 2'h0
`define CAC_RESP_SLVERR 2'h2
`endif

// ===== rtl/cac_pkg.sv
/*
 Types of the accelerator control block: algorithm and mode codes,
 soft reset states and the registered state record.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package cac_pkg;
    typedef enum logic [2:0] {
        CAC_ALG_OFF = 3'h0,
        CAC_ALG_AES128 = 3'h1,
        CAC_ALG_AES192 = 3'h2,
        CAC_ALG_AES256 = 3'h3,
        CAC_ALG_DES = 3'h4,
        CAC_ALG_TDES = 3'h5
    } cac_alg_t;
    typedef enum logic [2:0] {
        CAC_MODE_ECB = 3'h0,
        CAC_MODE_CBC = 3'h1,
        CAC_MODE_CFB = 3'h2,
        CAC_MODE_OFB = 3'h3,
        CAC_MODE_CTR = 3'h4,
        CAC_MODE_GCM = 3'h5,
        CAC_MODE_CCM = 3'h6
    } cac_mode_t;
    typedef enum logic {CAC_SR_IDLE, CAC_SR_BUSY} cac_sr_t;
    typedef struct packed {
        logic [31:0] data;
        logic full;
        logic valid;
    } cac_word_t;
    typedef struct packed {
        logic [31:0] main_ctl;
        logic [31:0] ciph_ctl;
        cac_sr_t sr_state;
        logic [7:0] sr_cnt;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        cac_word_t in_w;
        cac_word_t out_w;
        cac_word_t hash_w;
        logic key_load;
        logic key_from_nv;
        logic key_upper;
        logic irq;
    } cac_state_t;
endpackage

// ===== verification/cac_engine_model.sv
/*
 Engine-side model of the accelerator: on a go request it starts an
 H-vector computation and, DLY cycles later, ends it and reports a
 finished cipher block.
 Assumes go is a one-cycle request from the bench on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module cac_engine_model #(
    parameter int DLY = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic go,
    output logic hvc_start,
    output logic hvc_done,
    output logic cipher_done
);
    int cnt;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt <= 0;
            hvc_start <= 1'b0;
            hvc_done <= 1'b0;
            cipher_done <= 1'b0;
        end
        else
        begin
            hvc_start <= go && cnt == 0;
            cnt <= (go && cnt == 0) ? DLY : (cnt != 0 ? cnt - 1 : 0);
            hvc_done <= cnt == 1;
            cipher_done <= cnt == 1;
        end
    end
endmodule
`default_nettype wire

// ===== verification/tb_cac_control.sv
/*
 Self-checking bench of the accelerator control block over AXI4-Lite.
 Assumes the engine model beside it and a shortened soft reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_cac_control;
    import cac_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, v;
    logic awready, wready, bvalid, arready, rvalid, hs, hd, cd, srst, kls, knv, kup, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    cac_word_t fin = '0, fout = '0, ein, eout, hin;
    logic err = 1'b0, pay = 1'b0, go = 1'b0;
    logic [2:0] ccm_l = 3'h0, ccm_m = 3'h0;
    logic od = 1'b0;
    logic [3:0] wstrb = 4'hf;
    int failures = 0, n_checks = 0, kcnt = 0, scnt = 0, k, i;
    logic [31:0] kd [4] = '{32'h1a, 32'h1e, 32'h4a, 32'h12};
    logic [31:0] kn [4] = '{32'h1, 32'h1, 32'h0, 32'h0};
    logic [31:0] ku [4] = '{32'h0, 32'h1, 32'h0, 32'h0};

    cac_control #(.SRST_CYCLES(2)) cac_control_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .fifo_in(fin), .fifo_out(fout), .engine_in(ein), .engine_out(eout),
        .hash_in(hin), .cipher_done(cd), .other_done(od), .engine_err(err),
        .ccm_l(ccm_l), .ccm_m(ccm_m), .payload_phase(pay), .hvc_start(hs),
        .hvc_done(hd), .soft_reset(srst), .key_load_start(kls),
        .key_from_nv(knv), .key_upper_half(kup), .irq(irq)
    );
    cac_engine_model cac_engine_model_inst (
        .aclk(aclk), .aresetn(aresetn), .go(go), .hvc_start(hs), .hvc_done(hd),
        .cipher_done(cd)
    );

    initial
    begin
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        if (kls === 1'b1)
            kcnt++;
        if (srst === 1'b1)
            scnt++;
    end

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic to(input int t);
        if (t >= 50)
        begin
            failures++;
            $display("BAD wait expected answer seen timeout");
            final_report();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int j;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        @(negedge aclk);
        for (j = 0; j < 50 && (awready & wready) !== 1'b1; j++)
            @(negedge aclk);
        to(j);
        @(posedge aclk);
        awv <= 1'b0;
        wv <= 1'b0;
        @(negedge aclk);
        for (j = 0; j < 50 && bvalid !== 1'b1; j++)
            @(negedge aclk);
        to(j);
        chk("bresp", {30'h0, bresp}, {30'h0, er});
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
        int j;
        @(posedge aclk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        @(negedge aclk);
        for (j = 0; j < 50 && arready !== 1'b1; j++)
            @(negedge aclk);
        to(j);
        @(posedge aclk);
        arv <= 1'b0;
        @(negedge aclk);
        for (j = 0; j < 50 && rvalid !== 1'b1; j++)
            @(negedge aclk);
        to(j);
        d = rdata;
        chk("rresp", {30'h0, rresp}, {30'h0, er});
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic final_report;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h0, 2'h0, v);
        chk("main_rst", v, 32'h1000_0000);
        rd(4'h4, 2'h0, v);
        chk("ciph_rst", v, 32'h0);
        wr(4'h0, 32'hffff_ffbe, 2'h0);
        rd(4'h0, 2'h0, v);
        chk("main_rw", v, 32'h1800_0036);
        wr(4'h0, 32'h0, 2'h0);
        wr(4'h4, 32'hffff_ffff, 2'h0);
        rd(4'h4, 2'h0, v);
        chk("ciph_rw", v, 32'h0000_077f);
        wr(4'h4, 32'h0, 2'h0);
        wr(4'h8, 32'hffff_ffff, 2'h2);
        rd(4'h8, 2'h2, v);
        chk("unmapped", v, 32'h0);
        ccm_l <= 3'h7;
        ccm_m <= 3'h1;
        pay <= 1'b1;
        rd(4'h4, 2'h0, v);
        chk("ccm_ro", v, 32'h0007_3000);
        ccm_l <= 3'h1;
        ccm_m <= 3'h7;
        pay <= 1'b0;
        rd(4'h4, 2'h0, v);
        chk("ccm_ro2", v, 32'h0001_e000);
        for (k = 0; k < 8; k++)
        begin
            wr(4'h0, {26'h0, k[0], k[1], 1'b0, k[2], 2'b00}, 2'h0);
            fin <= '{32'h1122_3344, k != 7, 1'b1};
            fout <= '{32'haabb_ccdd, k != 7, 1'b1};
            settle(2);
            chk("eng_in", ein.data, (k[0] && k != 7) ? 32'h4433_2211 : 32'h1122_3344);
            chk("eng_out", eout.data, (k[1] && k != 7) ? 32'hddcc_bbaa : 32'haabb_ccdd);
            chk("hash_in", hin.data, k[2] ? 32'haabb_ccdd : 32'h1122_3344);
        end
        wr(4'h0, 32'h2, 2'h0);
        err <= 1'b1;
        settle(3);
        chk("irq_err", {31'h0, irq}, 32'h1);
        wr(4'h0, 32'h0, 2'h0);
        settle(3);
        chk("irq_off", {31'h0, irq}, 32'h0);
        @(posedge aclk) err <= 1'b0;
        wr(4'h0, 32'h2, 2'h0);
        od <= 1'b1;
        settle(3);
        chk("irq_other", {31'h0, irq}, 32'h1);
        @(posedge aclk) od <= 1'b0;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        rd(4'h4, 2'h0, v);
        chk("hvc_busy", {31'h0, v[11]}, 32'h1);
        settle(10);
        rd(4'h4, 2'h0, v);
        chk("hvc_end", {31'h0, v[11]}, 32'h0);
        rd(4'h0, 2'h0, v);
        chk("cph_done", v, 32'h1800_0002);
        settle(0);
        chk("irq_done", {31'h0, irq}, 32'h1);
        wr(4'h0, 32'h2, 2'h0);
        settle(3);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        @(posedge aclk) go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        wr(4'h0, 32'h23, 2'h0);
        for (i = 0; i < 50; i++)
        begin
            rd(4'h0, 2'h0, v);
            if (v[28] === 1'b1 && v[0] === 1'b0)
                break;
        end
        to(i);
        settle(0);
        chk("srst_len", scnt, 32'h2);
        chk("ctl_kept", v, 32'h1000_0022);
        rd(4'h4, 2'h0, v);
        chk("hvc_srst", {31'h0, v[11]}, 32'h0);
        wr(4'h0, 32'h22, 2'h0);
        settle(3);
        chk("srst_w0", scnt, 32'h2);
        @(posedge aclk) wstrb <= 4'he;
        wr(4'h0, 32'h0800_0001, 2'h0);
        rd(4'h0, 2'h0, v);
        chk("lane_mask", v, 32'h1800_0022);
        wstrb <= 4'hf;
        settle(0);
        chk("srst_lane", scnt, 32'h2);
        i = kcnt;
        for (k = 0; k < 4; k++)
        begin
            wr(4'h4, kd[k], 2'h0);
            settle(1);
            chk("key_nv", {31'h0, knv}, kn[k]);
            chk("key_up", {31'h0, kup}, ku[k]);
        end
        chk("key_load", kcnt - i, 32'h4);
        final_report();
    end
endmodule
`default_nettype wire
